// *** inc/dmasc_pkg.sv ***
// Function
// R1: Sync field selects one of four gating modes
// R2: Mode zero transfers freely, ignores all interrupts
// R3: Internal gating never alters interrupt-enable bits
// R4: Source mode: read waits for enabled interrupt
// R5: Destination mode ignores interrupts until read done
// R6: Destination mode: write waits for enabled interrupt
// R7: Both mode: read on one, write next
// R8: Count zero raises completion if irq enabled
// R9: CPU sees completion only with enable bit
// R10: Count zero stops engine when terminate set
// R11: Software sets terminate equal to irq enable
// R12: Both set: notify then stay halted, ready
// R13: Control, address, count registers are bus mapped
// R14: Clearing start field halts the engine
// R15: Reset leaves engine halted, nothing running
// R16: Software configures with start zero, then starts
// R17: Interrupts latched; control reset clears latch
// R18: CPU wins every conflict; engine waits
// R19: On-chip accesses happen in third clock phase
// R20: Each transfer is one read then write
// R21: Every moved element is a 32-bit word
// R22: Count per write; addresses step per access
// R23: Restart finishes any pending transfer first
// R24: External to same external: two plus waits each
// R25: On-chip to external: one setup cycle first
package dmasc_pkg;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 24;
	localparam int WAIT_W = 4;
	// Sync modes
	localparam logic [1:0] SYNC_NONE = 2'h0;
	localparam logic [1:0] SYNC_SRC  = 2'h1;
	localparam logic [1:0] SYNC_DST  = 2'h2;
	localparam logic [1:0] SYNC_BOTH = 2'h3;
	// Start field values
	localparam logic [1:0] START_RUN = 2'h3;
	// Bit of the interrupt-enable register for CPU completion
	localparam int IE_CPU_DMA_BIT = 10;
	// Bus region codes
	localparam logic [1:0] REG_ONCHIP = 2'h0;
	localparam logic [1:0] REG_PRIM   = 2'h1;
	localparam logic [1:0] REG_EXP    = 2'h2;
	// Clock phases per processor cycle and the on-chip phase
	localparam logic [1:0] PHASE_LAST  = 2'h3;
	localparam logic [1:0] PHASE_ONCHP = 2'h2;
	// Fixed external access cycles before wait states
	localparam logic [WAIT_W:0] EXT_BASE = 5'h2;
	localparam logic [WAIT_W:0] SETUP_CYC = 5'h1;
	// Reset values
	localparam logic [ADDR_W-1:0] ADDR_RST = 24'h000000;
	localparam logic [ADDR_W-1:0] CNT_RST  = 24'h000000;
	typedef enum logic [2:0] {
		DMASC_IDLE  = 3'h0,
		DMASC_SETUP = 3'h1,
		DMASC_RWAIT = 3'h3,
		DMASC_READ  = 3'h2,
		DMASC_WWAIT = 3'h6,
		DMASC_WRITE = 3'h7
	} dmasc_state_t;
endpackage

// *** core/dmasc_access_timer.sv ***
`timescale 1ns/1ps
// Counts the length of one bus access: on-chip accesses wait for the
// third phase, external ones take a base count plus wait states.
module dmasc_access_timer
	import dmasc_pkg::*;
(
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              rst_n,
	// Access request
	input  wire logic              start,
	input  wire logic [1:0]        region,
	input  wire logic [WAIT_W-1:0] waits,
	input  wire logic [1:0]        phase,
	input  wire logic              cpu_conflict,
	// Completion
	output logic                   done
);
	logic [WAIT_W:0] cnt;        // Cycles left in access
	logic [WAIT_W:0] next_cnt;
	logic            busy;       // Access in flight
	logic            next_busy;
	logic            onchip;     // Current access is on-chip
	logic            next_onchip;

	// Next-state for the access counter
	always_comb begin
		next_cnt    = cnt;
		next_busy   = busy;
		next_onchip = onchip;
		done        = 1'b0;
		if (start && !busy) begin
			next_busy   = 1'b1;
			next_onchip = (region == REG_ONCHIP);
			next_cnt    = EXT_BASE + {1'b0, waits} - 5'h1; // [R24]
		end else if (busy && !cpu_conflict) begin // [R18]
			if (onchip) begin
				// Single-cycle, taken only in the third phase
				if (phase == PHASE_ONCHP) begin // [R19]
					done      = 1'b1;
					next_busy = 1'b0;
				end
			end else if (cnt == 5'h0) begin
				done      = 1'b1;
				next_busy = 1'b0;
			end else begin
				next_cnt = cnt - 5'h1;
			end
		end
	end

	// Register the counter
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt    <= 5'h0;
			busy   <= 1'b0;
			onchip <= 1'b0;
		end else begin
			cnt    <= next_cnt;
			busy   <= next_busy;
			onchip <= next_onchip;
		end
	end
endmodule

// *** core/dmasc_top.sv ***
`timescale 1ns/1ps
// Single-channel transfer sequencer with interrupt gating.
module dmasc_top
	import dmasc_pkg::*;
(
	// Clock and reset
	input  wire logic              CLOCK,
	input  wire logic              RST_N,
	// Global control fields
	input  wire logic [1:0]        START_FIELD,
	input  wire logic [1:0]        SYNC_SELECT,
	input  wire logic              COUNT_ZERO_IRQ_ENABLE,
	input  wire logic              COUNT_ZERO_TERMINATE,
	input  wire logic              SOURCE_STEP_UP,
	input  wire logic              SOURCE_STEP_DOWN,
	input  wire logic              DEST_STEP_UP,
	input  wire logic              DEST_STEP_DOWN,
	input  wire logic              CONTROL_RESET,
	// Address and count load
	input  wire logic              LOAD_REGS,
	input  wire logic [ADDR_W-1:0] SOURCE_INIT,
	input  wire logic [ADDR_W-1:0] DEST_INIT,
	input  wire logic [ADDR_W-1:0] COUNT_INIT,
	// Bus regions and wait states
	input  wire logic [1:0]        SOURCE_REGION,
	input  wire logic [1:0]        DEST_REGION,
	input  wire logic [WAIT_W-1:0] READ_WAITS,
	input  wire logic [WAIT_W-1:0] WRITE_WAITS,
	// Interrupts and enables
	input  wire logic [15:0]       IRQ_IN,
	input  wire logic [31:0]       IRQ_ENABLE_REGISTER,
	// CPU contention
	input  wire logic              CPU_CONFLICT,
	// Memory side
	input  wire logic [DATA_W-1:0] READ_DATA,
	output logic                   READ_STROBE,
	output logic                   WRITE_STROBE,
	output logic [ADDR_W-1:0]      BUS_ADDR,
	output logic [DATA_W-1:0]      WRITE_DATA,
	// Status
	output logic [ADDR_W-1:0]      SOURCE_ADDR,
	output logic [ADDR_W-1:0]      DEST_ADDR,
	output logic [ADDR_W-1:0]      TRANSFER_COUNT,
	output logic                   RUNNING,
	output logic                   CPU_DONE_IRQ
);
	// Internal state
	dmasc_state_t      state;         // Sequencer state
	dmasc_state_t      next_state;
	logic [ADDR_W-1:0] src;           // Source address
	logic [ADDR_W-1:0] next_src;
	logic [ADDR_W-1:0] dst;           // Destination address
	logic [ADDR_W-1:0] next_dst;
	logic [ADDR_W-1:0] cnt;           // Transfer count
	logic [ADDR_W-1:0] next_cnt;
	logic [DATA_W-1:0] data;          // Word held between read and write
	logic [DATA_W-1:0] next_data;
	logic              latched;       // Latched interrupt request
	logic              next_latched;
	logic              pending;       // Read done, write outstanding
	logic              next_pending;
	logic              irq;           // Completion pulse register
	logic              next_irq;
	logic              rd_stb;
	logic              next_rd_stb;
	logic              wr_stb;
	logic              next_wr_stb;
	logic [ADDR_W-1:0] addr;
	logic [ADDR_W-1:0] next_addr;
	logic              setup_done;    // One setup cycle taken this run
	logic              next_setup_done;
	logic [1:0]        phase;         // Clock phase within processor cycle
	logic [1:0]        next_phase;
	// Synchronised interrupt lines
	logic [15:0]       irq_meta;
	logic [15:0]       irq_sync;
	logic [15:0]       irq_prev;
	// Timer handshake
	logic              acc_start;
	logic [1:0]        acc_region;
	logic [WAIT_W-1:0] acc_waits;
	logic              acc_done;
	logic              run;
	logic              gate_open;
	logic              new_irq;
	logic              running;       // Registered busy status for the RUNNING pin
	logic              next_running;

	// Step an address up, down or not at all
	function automatic logic [ADDR_W-1:0] step_addr(input logic [ADDR_W-1:0] a,
		input logic up, input logic down);
		if (up)
			step_addr = a + 24'h000001;
		else if (down)
			step_addr = a - 24'h000001;
		else
			step_addr = a;
	endfunction

	// Two-flop synchroniser for the external interrupt lines
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			irq_meta <= 16'h0000;
			irq_sync <= 16'h0000;
			irq_prev <= 16'h0000;
		end else begin
			irq_meta <= IRQ_IN;
			irq_sync <= irq_meta;
			irq_prev <= irq_sync;
		end
	end

	// Rising edge on a line the DMA half of the enable register allows.
	// The enable register is only read, never written, so internal
	// gating leaves its bits untouched. [R3]
	assign new_irq = |(irq_sync & ~irq_prev & IRQ_ENABLE_REGISTER[31:16]);
	assign run     = (START_FIELD == START_RUN); // [R14]

	// Gate decision: which access may go now in the current mode
	always_comb begin
		gate_open = 1'b0;
		case (SYNC_SELECT) // [R1]
			SYNC_NONE: gate_open = 1'b1; // [R2]
			SYNC_SRC:  gate_open = pending ? 1'b1 : latched; // [R4]
			SYNC_DST:  gate_open = pending ? latched : 1'b1; // [R5] [R6]
			SYNC_BOTH: gate_open = latched; // [R7]
			default:   gate_open = 1'b0;
		endcase
	end

	// Region and waits for the next access
	always_comb begin
		acc_region = pending ? DEST_REGION : SOURCE_REGION;
		acc_waits  = pending ? WRITE_WAITS : READ_WAITS;
		// A write access starts only when its gate opens, so a held write never runs the timer early
		acc_start  = (state == DMASC_RWAIT) || (state == DMASC_WWAIT && gate_open && run);
	end

	// Access timer
	dmasc_access_timer u_timer (
		.clk          (CLOCK),
		.rst_n        (RST_N),
		.start        (acc_start),
		.region       (acc_region),
		.waits        (acc_waits),
		.phase        (phase),
		.cpu_conflict (CPU_CONFLICT),
		.done         (acc_done)
	);

	// Sequencer next-state
	always_comb begin
		next_state      = state;
		next_src        = src;
		next_dst        = dst;
		next_cnt        = cnt;
		next_data       = data;
		next_latched    = latched;
		next_pending    = pending;
		next_irq        = 1'b0;
		next_rd_stb     = 1'b0;
		next_wr_stb     = 1'b0;
		next_addr       = addr;
		next_setup_done = setup_done;
		next_phase      = (phase == PHASE_LAST) ? 2'h0 : phase + 2'h1;
		// Latch interrupts; mode zero and ungated windows ignore them
		if (new_irq && SYNC_SELECT != SYNC_NONE) // [R17] [R2]
			next_latched = 1'b1;
		if (SYNC_SELECT == SYNC_DST && !pending)
			next_latched = 1'b0; // [R5]
		// Source mode: once a read is triggered, events are ignored until the word is done
		if (SYNC_SELECT == SYNC_SRC && state != DMASC_IDLE && state != DMASC_SETUP)
			next_latched = 1'b0; // [R4]
		if (LOAD_REGS) begin
			next_src = SOURCE_INIT;
			next_dst = DEST_INIT;
			next_cnt = COUNT_INIT;
		end
		case (state)
			DMASC_IDLE: begin
				if (run && !LOAD_REGS) begin
					// A pending write resumes first after a restart [R23]
					next_state = pending ? DMASC_WWAIT : DMASC_SETUP;
				end
			end
			DMASC_SETUP: begin
				if (!run)
					next_state = DMASC_IDLE;
				else if (gate_open) begin
					// On-chip to external spends one setup cycle per run [R25]
					if (!setup_done && SOURCE_REGION == REG_ONCHIP && DEST_REGION != REG_ONCHIP)
						next_setup_done = 1'b1;
					else begin
						next_state = DMASC_RWAIT;
						// Address stands for the whole access so the far side can answer
						next_addr  = src;
						if (SYNC_SELECT != SYNC_NONE)
							next_latched = 1'b0; // [R4] [R7]
					end
				end
			end
			DMASC_RWAIT: begin
				next_state = DMASC_READ;
			end
			DMASC_READ: begin
				if (acc_done) begin
					next_data    = READ_DATA; // [R21]
					next_rd_stb  = 1'b1;
					next_src     = step_addr(src, SOURCE_STEP_UP, SOURCE_STEP_DOWN); // [R22]
					next_pending = 1'b1;
					next_state   = run ? DMASC_WWAIT : DMASC_IDLE;
				end
			end
			DMASC_WWAIT: begin
				if (!run)
					next_state = DMASC_IDLE;
				else if (gate_open) begin
					next_state = DMASC_WRITE;
					next_addr  = dst;
					if (SYNC_SELECT != SYNC_NONE)
						next_latched = 1'b0; // [R6] [R7]
				end
			end
			DMASC_WRITE: begin
				if (acc_done) begin
					next_wr_stb  = 1'b1; // [R20]
					next_dst     = step_addr(dst, DEST_STEP_UP, DEST_STEP_DOWN); // [R22]
					next_cnt     = cnt - 24'h000001; // [R22]
					next_pending = 1'b0;
					next_state   = DMASC_SETUP;
					if (cnt == 24'h000001) begin
						// CPU sees completion only with its enable bit [R8] [R9]
						next_irq = COUNT_ZERO_IRQ_ENABLE && IRQ_ENABLE_REGISTER[IE_CPU_DMA_BIT];
						if (COUNT_ZERO_TERMINATE)
							next_state = DMASC_IDLE; // [R10] [R12]
					end
					if (!run)
						next_state = DMASC_IDLE;
				end
			end
			default: next_state = DMASC_IDLE;
		endcase
		// Wait for a re-arm after termination so a halted run does not restart itself
		if (state == DMASC_IDLE && cnt == 24'h000000 && COUNT_ZERO_TERMINATE)
			next_state = DMASC_IDLE; // [R12]
		// Control reset drops latched request and pending work [R17]
		if (CONTROL_RESET) begin
			next_latched    = 1'b0;
			next_pending    = 1'b0;
			next_setup_done = 1'b0;
			next_state      = DMASC_IDLE;
		end
		if (state == DMASC_IDLE && !run)
			next_setup_done = 1'b0;
		// Busy status follows the next state, so the pin matches the state register
		next_running = (next_state != DMASC_IDLE);
	end

	// Register the sequencer; reset leaves it halted [R15]
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			state      <= DMASC_IDLE;
			src        <= ADDR_RST;
			dst        <= ADDR_RST;
			cnt        <= CNT_RST;
			data       <= 32'h00000000;
			latched    <= 1'b0;
			pending    <= 1'b0;
			irq        <= 1'b0;
			rd_stb     <= 1'b0;
			wr_stb     <= 1'b0;
			addr       <= ADDR_RST;
			setup_done <= 1'b0;
			phase      <= 2'h0;
			running    <= 1'b0;
		end else begin
			state      <= next_state;
			src        <= next_src;
			dst        <= next_dst;
			cnt        <= next_cnt;
			data       <= next_data;
			latched    <= next_latched;
			pending    <= next_pending;
			irq        <= next_irq;
			rd_stb     <= next_rd_stb;
			wr_stb     <= next_wr_stb;
			addr       <= next_addr;
			setup_done <= next_setup_done;
			phase      <= next_phase;
			running    <= next_running;
		end
	end

	// Status outputs are the registers themselves [R13]
	always_comb begin
		READ_STROBE    = rd_stb;
		WRITE_STROBE   = wr_stb;
		BUS_ADDR       = addr;
		WRITE_DATA     = data;
		SOURCE_ADDR    = src;
		DEST_ADDR      = dst;
		TRANSFER_COUNT = cnt;
		RUNNING        = running;
		CPU_DONE_IRQ   = irq;
	end
endmodule

// *** test/dmasc_top_asserts.sv ***
`timescale 1ns/1ps
// Port checks on transfer order, gating and halting
module dmasc_checker
	import dmasc_pkg::*;
(
	// Clock and reset
	input wire logic              CLOCK,
	input wire logic              RST_N,
	// Controls
	input wire logic [1:0]        START_FIELD,
	input wire logic              COUNT_ZERO_IRQ_ENABLE,
	input wire logic              COUNT_ZERO_TERMINATE,
	input wire logic              CONTROL_RESET,
	input wire logic              LOAD_REGS,
	input wire logic [31:0]       IRQ_ENABLE_REGISTER,
	input wire logic              CPU_CONFLICT,
	// Engine outputs
	input wire logic              READ_STROBE,
	input wire logic              WRITE_STROBE,
	input wire logic [ADDR_W-1:0] TRANSFER_COUNT,
	input wire logic              RUNNING,
	input wire logic              CPU_DONE_IRQ
);
	logic rd_open; // Read done, write still owed
	// Control reset drops the owed write, so the tracker clears too
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N)
			rd_open <= 1'b0;
		else if (READ_STROBE || WRITE_STROBE || CONTROL_RESET)
			rd_open <= READ_STROBE && !CONTROL_RESET;
	end
	logic [4:0] halt_cnt; // Cycles halted with the bus free, saturating
	// An access in flight may finish after the halt, so allow it time
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N)
			halt_cnt <= 5'h00;
		else if (START_FIELD == START_RUN || CPU_CONFLICT)
			halt_cnt <= 5'h00;
		else if (halt_cnt != 5'h18)
			halt_cnt <= halt_cnt + 5'h01;
	end
	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (!RST_N);
	a_read_order: assert property (READ_STROBE |-> !rd_open && !WRITE_STROBE)
		else $error("read while write owed");
	a_write_after_read: assert property (WRITE_STROBE |-> rd_open)
		else $error("write without read");
	a_count_step: assert property ($changed(TRANSFER_COUNT) && !$past(LOAD_REGS) && !$past(CONTROL_RESET)
		|-> TRANSFER_COUNT == $past(TRANSFER_COUNT) - 24'h000001) else $error("count step wrong");
	a_done_gated: assert property (CPU_DONE_IRQ |-> $past(COUNT_ZERO_IRQ_ENABLE) && $past(IRQ_ENABLE_REGISTER[IE_CPU_DMA_BIT]))
		else $error("completion not enabled");
	a_stop_at_zero: assert property ($changed(TRANSFER_COUNT) && TRANSFER_COUNT == 24'h000000 && COUNT_ZERO_TERMINATE
		|=> (!READ_STROBE) [*8]) else $error("read after terminal count");
	a_halt_quiet: assert property (halt_cnt == 5'h18 |-> !RUNNING && !READ_STROBE)
		else $error("active while halted");
	a_reset_idle: assert property ($rose(RST_N) |-> !RUNNING && !READ_STROBE && !WRITE_STROBE)
		else $error("active out of reset");
	a_cpu_wins: assert property (CPU_CONFLICT [*4] |-> !READ_STROBE && !WRITE_STROBE)
		else $error("access in conflict");
	c_done: cover property (CPU_DONE_IRQ);
	c_stall: cover property (CPU_CONFLICT [*4]);
	c_pair: cover property (READ_STROBE ##[1:40] WRITE_STROBE);
endmodule
bind dmasc_top dmasc_checker u_chk (.CLOCK(CLOCK), .RST_N(RST_N), .START_FIELD(START_FIELD),
	.COUNT_ZERO_IRQ_ENABLE(COUNT_ZERO_IRQ_ENABLE), .COUNT_ZERO_TERMINATE(COUNT_ZERO_TERMINATE),
	.CONTROL_RESET(CONTROL_RESET), .LOAD_REGS(LOAD_REGS), .IRQ_ENABLE_REGISTER(IRQ_ENABLE_REGISTER),
	.CPU_CONFLICT(CPU_CONFLICT), .READ_STROBE(READ_STROBE), .WRITE_STROBE(WRITE_STROBE),
	.TRANSFER_COUNT(TRANSFER_COUNT), .RUNNING(RUNNING), .CPU_DONE_IRQ(CPU_DONE_IRQ));

// *** test/dmasc_mem_model.sv ***
`timescale 1ns/1ps
// Far-side word memory, answering from the bus address
module dmasc_mem_model
	import dmasc_pkg::*;
(
	// Clock
	input  wire logic              clk,
	// Engine access
	input  wire logic              rd,
	input  wire logic              wr,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [DATA_W-1:0] wdata,
	output logic      [DATA_W-1:0] rdata
);
	logic [DATA_W-1:0] mem [0:255]; // Low address bits only, blocks alias
	int                n_rd = 0;    // Reads seen
	int                n_wr = 0;    // Writes seen
	// Distinct fill so a wrong word shows
	initial begin
		for (int i = 0; i < 256; i++)
			mem[i] = {16'hC0DE, 8'h00, i[7:0]};
	end
	assign rdata = mem[addr[7:0]]; // Whole 32-bit word
	// Count accesses and store written words
	always @(posedge clk) begin
		if (rd)
			n_rd++;
		if (wr) begin // One write per read
			n_wr++;
			mem[addr[7:0]] <= wdata;
		end
	end
endmodule

// *** test/tb_top.sv ***
`timescale 1ns/1ps
// Bench: sync modes, count zero, halting
module tb_top
	import dmasc_pkg::*;
	;
	logic              clock = 1'b0;
	logic              rst_n = 1'b0;
	logic [1:0]        start = 2'h0, mode = 2'h0, sreg = 2'h0, dreg = 2'h0;
	logic              irq_en = 1'b1, term = 1'b1, ctl = 1'b0, load = 1'b0, cpu = 1'b0, d_up = 1'b1;
	logic [ADDR_W-1:0] cnt = 24'h000000, s_addr, d_addr, tcount, b_addr;
	logic [WAIT_W-1:0] waits = 4'h0;
	logic [15:0]       irq = 16'h0000;
	logic [31:0]       ie = 32'h00010400; // DMA line 0 and CPU completion
	logic [DATA_W-1:0] rdata, wdata;
	logic              rd, wr, run, done;
	int                n_fail = 0, samples_checked = 0, n_done = 0, k;
	always #4 clock = ~clock;
	// Count completion pulses
	always @(posedge clock) begin
		if (done === 1'b1)
			n_done++;
	end
	dmasc_top u_dut (.CLOCK(clock), .RST_N(rst_n), .START_FIELD(start), .SYNC_SELECT(mode),
		.COUNT_ZERO_IRQ_ENABLE(irq_en), .COUNT_ZERO_TERMINATE(term), .SOURCE_STEP_UP(d_up),
		.SOURCE_STEP_DOWN(!d_up), .DEST_STEP_UP(d_up), .DEST_STEP_DOWN(!d_up), .CONTROL_RESET(ctl),
		.LOAD_REGS(load), .SOURCE_INIT(24'h000010), .DEST_INIT(24'h000080), .COUNT_INIT(cnt),
		.SOURCE_REGION(sreg), .DEST_REGION(dreg), .READ_WAITS(waits), .WRITE_WAITS(waits),
		.IRQ_IN(irq), .IRQ_ENABLE_REGISTER(ie), .CPU_CONFLICT(cpu), .READ_DATA(rdata),
		.READ_STROBE(rd), .WRITE_STROBE(wr), .BUS_ADDR(b_addr), .WRITE_DATA(wdata),
		.SOURCE_ADDR(s_addr), .DEST_ADDR(d_addr), .TRANSFER_COUNT(tcount), .RUNNING(run),
		.CPU_DONE_IRQ(done));
	dmasc_mem_model u_mem (.clk(clock), .rd(rd), .wr(wr), .addr(b_addr), .wdata(wdata), .rdata(rdata));
	task automatic finish_test();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge clock);
	endtask
	// Load while halted with stale events dropped, then start
	task automatic arm(input logic [1:0] m, input logic [23:0] n, input logic [1:0] s, d, input logic [3:0] w);
		start = 2'h0;
		ctl = 1'b1;
		load = 1'b1;
		mode = m;
		cnt = n;
		sreg = s;
		dreg = d;
		waits = w;
		tick(1);
		ctl = 1'b0;
		load = 1'b0;
		start = START_RUN;
		n_done = 0;
		u_mem.n_rd = 0;
		u_mem.n_wr = 0;
	endtask
	// One rising event on a line, held long enough for the synchroniser
	task automatic pulse(input int b);
		irq[b] = 1'b1;
		tick(4);
		irq[b] = 1'b0;
		tick(4);
	endtask
	// Bounded wait for a write count
	task automatic wait_writes(input int n);
		int i;
		for (i = 0; i < 400 && u_mem.n_wr < n; i++)
			tick(1);
		check("write wait", 1, i < 400);
		if (i >= 400)
			finish_test();
	endtask
	initial begin
		tick(16);
		rst_n = 1'b1;
		tick(1);
		check("running", 0, run);
		// Free copy while the CPU holds the bus first; the event is ignored
		cpu = 1'b1;
		arm(SYNC_NONE, 3, REG_ONCHIP, REG_ONCHIP, 4'h0);
		pulse(0);
		tick(12);
		check("stalled reads", 0, u_mem.n_rd);
		cpu = 1'b0;
		wait_writes(3);
		tick(10);
		check("reads", 3, u_mem.n_rd);
		check("writes", 3, u_mem.n_wr);
		check("done", 1, n_done);
		check("halted", 0, run);
		check("src addr", 24'h000013, s_addr);
		check("count", 0, tcount);
		for (int i = 0; i < 3; i++)
			check("word", {16'hC0DE, 8'h00, 8'h10 + i[7:0]}, u_mem.mem[8'h80 + i]);
		// Bus to bus, both addresses stepping down, CPU completion masked
		ie = 32'h00010000;
		d_up = 1'b0;
		arm(SYNC_NONE, 2, REG_PRIM, REG_EXP, 4'h3);
		wait_writes(2);
		tick(10);
		check("masked done", 0, n_done);
		check("dst addr", 24'h00007E, d_addr);
		check("src down", 24'h00000E, s_addr);
		ie = 32'h00010400;
		d_up = 1'b1;
		// Source gated: disabled line does nothing, enabled one moves a word
		// On-chip to bus also spends the one setup cycle
		arm(SYNC_SRC, 2, REG_ONCHIP, REG_PRIM, 4'h0);
		pulse(1);
		tick(30);
		check("ungated", 0, u_mem.n_rd);
		pulse(0);
		tick(30);
		check("one word", 1, u_mem.n_wr);
		check("count left", 1, tcount);
		// Destination gated: early event ignored; halt and restart keep the owed write
		arm(SYNC_DST, 1, REG_EXP, REG_ONCHIP, 4'hF);
		pulse(0);
		tick(40);
		check("read done", 1, u_mem.n_rd);
		check("write held", 0, u_mem.n_wr);
		start = 2'h0;
		tick(10);
		start = START_RUN;
		pulse(0);
		tick(30);
		check("gated write", 1, u_mem.n_wr);
		check("no reread", 1, u_mem.n_rd);
		// Both gated: read on one event, write on the next
		arm(SYNC_BOTH, 1, REG_ONCHIP, REG_ONCHIP, 4'h0);
		pulse(0);
		tick(30);
		check("first event", 0, u_mem.n_wr);
		pulse(0);
		tick(30);
		check("second event", 1, u_mem.n_wr);
		// Event seen while halted is dropped by the control reset
		start = 2'h0;
		mode = SYNC_SRC;
		pulse(0);
		arm(SYNC_SRC, 1, REG_ONCHIP, REG_ONCHIP, 4'h0);
		tick(30);
		check("stale event", 0, u_mem.n_rd);
		// No stop at zero until the start field clears
		irq_en = 1'b0;
		term = 1'b0;
		arm(SYNC_NONE, 1, REG_ONCHIP, REG_ONCHIP, 4'h0);
		tick(60);
		check("past zero", 1, u_mem.n_wr > 1);
		start = 2'h0;
		tick(10);
		k = u_mem.n_wr;
		tick(30);
		check("stopped", k, u_mem.n_wr);
		finish_test();
	end
endmodule
